// file: design/fdc_cal_regs.sv
// Purpose: key-protected gain and offset trim registers for the wave dac
// Assumes: one clock, asynchronous active-high reset, axi4-lite slave
// Notes:   selected trims are driven out for the dac datapath
`timescale 1ns/100ps

module fdc_cal_regs
   import fdc_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RESET,
   input  wire logic [15:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [15:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic        HIGH_SPEED_MODE,
   output logic [11:0]      GAIN_TRIM,
   output logic [11:0]      OFFSET_TRIM,
   output logic             ATTEN_ENABLE,
   output logic             GAIN_SELECT,
   output logic             CAL_UNLOCKED
);

   // -----------------------------------------------------------------
   // storage
   // -----------------------------------------------------------------
   logic [31:0]   key_ff;
   logic [11:0]   gain_ff;
   logic [11:0]   ofs_ff [4];
   logic [31:0]   cfg_ff;
   logic [15:0]   awaddr_ff;
   logic          aw_have_ff;
   logic [31:0]   wdata_ff;
   logic [3:0]    wstrb_ff;
   logic          w_have_ff;
   logic          bvalid_ff;
   logic [1:0]    bresp_ff;
   logic          rvalid_ff;
   logic [31:0]   rdata_ff;
   logic [1:0]    rresp_ff;
   logic [11:0]   gain_out_ff;
   logic [11:0]   ofs_out_ff;
   logic          do_write;
   logic          unlocked;
   logic [31:0]   merged;
   logic [31:0]   nxt_rdata;
   logic          nxt_rhit;
   logic          wr_hit;
   int            wr_idx;
   logic [1:0]    sel_idx;
   logic          wen_key;
   logic          wen_cfg;
   logic          wen_gain;
   logic [3:0]    wen_ofs;
   logic          wr_busy;
   fdc_wstate_t   wstate_ff;
   fdc_wstate_t   nxt_wstate;

   assign unlocked = (key_ff == KEY_UNLOCK);
   assign CAL_UNLOCKED = unlocked;

   // -----------------------------------------------------------------
   // write phase tracking
   // -----------------------------------------------------------------
   always_comb begin
      nxt_wstate = wstate_ff;
      unique case (wstate_ff)
         FDC_W_IDLE: begin
            if (do_write) begin
               nxt_wstate = FDC_W_RESP;
            end else if (aw_have_ff || w_have_ff) begin
               nxt_wstate = FDC_W_HOLD;
            end
         end
         FDC_W_HOLD: begin
            if (do_write) begin
               nxt_wstate = FDC_W_RESP;
            end
         end
         FDC_W_RESP: begin
            if (S_AXI_BREADY) begin
               nxt_wstate = FDC_W_IDLE;
            end
         end
         default: begin
            nxt_wstate = FDC_W_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         wstate_ff <= FDC_W_IDLE;
      end else begin
         wstate_ff <= nxt_wstate;
      end
   end

   // response pending: no new address or data taken
   assign wr_busy = (wstate_ff == FDC_W_RESP);

   // -----------------------------------------------------------------
   // write enables
   // -----------------------------------------------------------------
   always_comb begin
      wen_key  = 1'b0;
      wen_cfg  = 1'b0;
      wen_gain = 1'b0;
      wen_ofs  = 4'h0;
      if (do_write && wr_hit) begin
         unique case (awaddr_ff)
            OFS_UNLOCK_KEY: begin
               wen_key = 1'b1;
            end
            OFS_DAC_CONFIG: begin
               wen_cfg = 1'b1;
            end
            OFS_GAIN_TRIM: begin
               wen_gain = unlocked;
            end
            default: begin
               wen_ofs[wr_idx[1:0]] = unlocked;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // write channel capture
   // -----------------------------------------------------------------
   assign S_AXI_AWREADY = !aw_have_ff && !wr_busy;
   assign S_AXI_WREADY  = !w_have_ff && !wr_busy;
   assign do_write      = aw_have_ff && w_have_ff && !wr_busy;

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         aw_have_ff <= 1'b0;
         awaddr_ff  <= 16'h0000;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_have_ff <= 1'b1;
         awaddr_ff  <= S_AXI_AWADDR;
      end else if (do_write) begin
         aw_have_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         w_have_ff <= 1'b0;
         wdata_ff  <= 32'h00000000;
         wstrb_ff  <= 4'h0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_have_ff <= 1'b1;
         wdata_ff  <= S_AXI_WDATA;
         wstrb_ff  <= S_AXI_WSTRB;
      end else if (do_write) begin
         w_have_ff <= 1'b0;
      end
   end

   // byte-lane merge helper
   function automatic logic [31:0] fdc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // -----------------------------------------------------------------
   // write decode
   // -----------------------------------------------------------------
   always_comb begin
      wr_hit = 1'b1;
      wr_idx = 0;
      merged = 32'h00000000;
      unique case (awaddr_ff)
         OFS_UNLOCK_KEY:   merged = fdc_merge(key_ff, wdata_ff, wstrb_ff);
         OFS_DAC_CONFIG:   merged = fdc_merge(cfg_ff, wdata_ff, wstrb_ff);
         OFS_GAIN_TRIM:    merged = fdc_merge({20'h0, gain_ff}, wdata_ff, wstrb_ff);
         OFS_ON_LOWPOWER:  begin
            wr_idx = 0;
            merged = fdc_merge({20'h0, ofs_ff[0]}, wdata_ff, wstrb_ff);
         end
         OFS_OFF_LOWPOWER: begin
            wr_idx = 1;
            merged = fdc_merge({20'h0, ofs_ff[1]}, wdata_ff, wstrb_ff);
         end
         OFS_ON_FAST:      begin
            wr_idx = 2;
            merged = fdc_merge({20'h0, ofs_ff[2]}, wdata_ff, wstrb_ff);
         end
         OFS_OFF_FAST:     begin
            wr_idx = 3;
            merged = fdc_merge({20'h0, ofs_ff[3]}, wdata_ff, wstrb_ff);
         end
         default:          wr_hit = 1'b0;
      endcase
   end

   // -----------------------------------------------------------------
   // key, config and trim registers
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         key_ff <= KEY_RESET;
      end else if (wen_key) begin
         key_ff <= merged;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         cfg_ff <= CONFIG_RESET;
      end else if (wen_cfg) begin
         cfg_ff <= merged & CONFIG_RW_MASK;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         gain_ff <= GAIN_RESET;
      end else if (wen_gain) begin
         gain_ff <= merged[TRIM_W-1:0];
      end
   end

   // offsets: 0 on/lowpower, 1 off/lowpower, 2 on/fast, 3 off/fast
   for (genvar g = 0; g < 4; g++) begin : g_ofs
      always_ff @(posedge CLK_SYS or posedge RESET) begin
         if (RESET) begin
            ofs_ff[g] <= OFFSET_RESET;
         end else if (wen_ofs[g]) begin
            ofs_ff[g] <= merged[TRIM_W-1:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // write response
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_ff <= 1'b0;
      end
   end
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP  = bresp_ff;

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   assign S_AXI_ARREADY = !rvalid_ff;

   always_comb begin
      nxt_rhit  = 1'b1;
      nxt_rdata = 32'h00000000;
      unique case (S_AXI_ARADDR)
         OFS_UNLOCK_KEY:   nxt_rdata = key_ff;
         OFS_DAC_CONFIG:   nxt_rdata = cfg_ff;
         OFS_GAIN_TRIM:    nxt_rdata = {20'h0, gain_ff};
         OFS_ON_LOWPOWER:  nxt_rdata = {20'h0, ofs_ff[0]};
         OFS_OFF_LOWPOWER: nxt_rdata = {20'h0, ofs_ff[1]};
         OFS_ON_FAST:      nxt_rdata = {20'h0, ofs_ff[2]};
         OFS_OFF_FAST:     nxt_rdata = {20'h0, ofs_ff[3]};
         default:          nxt_rhit  = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h00000000;
         rresp_ff  <= RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= nxt_rdata;
         rresp_ff  <= nxt_rhit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         rvalid_ff <= 1'b0;
      end
   end
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA  = rdata_ff;
   assign S_AXI_RRESP  = rresp_ff;

   // -----------------------------------------------------------------
   // trim selection for the datapath
   // -----------------------------------------------------------------
   assign sel_idx = {HIGH_SPEED_MODE, !cfg_ff[CFG_ATTEN_BIT]};

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         gain_out_ff <= GAIN_RESET;
         ofs_out_ff  <= OFFSET_RESET;
      end else begin
         gain_out_ff <= gain_ff;
         ofs_out_ff  <= ofs_ff[sel_idx];
      end
   end
   assign GAIN_TRIM    = gain_out_ff;
   assign OFFSET_TRIM  = ofs_out_ff;
   assign ATTEN_ENABLE = cfg_ff[CFG_ATTEN_BIT];
   assign GAIN_SELECT  = cfg_ff[CFG_GAINSEL_BIT];

endmodule // fdc_cal_regs

// file: design/fdc_pkg.sv
// Purpose: constants for the wave dac calibration register bank
// Assumes: axi4-lite, 32-bit data, byte addresses as printed
// Notes:   offsets, resets and field layouts shared by design and bench
package fdc_pkg;
   localparam int          ADDR_W            = 16;
   localparam int          TRIM_W            = 12;
   localparam logic [15:0] OFS_UNLOCK_KEY    = 16'h2230;
   localparam logic [15:0] OFS_GAIN_TRIM     = 16'h2260;
   localparam logic [15:0] OFS_ON_LOWPOWER   = 16'h2264;
   localparam logic [15:0] OFS_OFF_LOWPOWER  = 16'h2268;
   localparam logic [15:0] OFS_ON_FAST       = 16'h22b8;
   localparam logic [15:0] OFS_OFF_FAST      = 16'h22bc;
   localparam logic [15:0] OFS_DAC_CONFIG    = 16'h2010;
   localparam logic [31:0] KEY_RESET         = 32'hde87a5a0;
   localparam logic [31:0] KEY_UNLOCK        = 32'hde87a5af;
   localparam logic [11:0] GAIN_RESET        = 12'h800;
   localparam logic [11:0] OFFSET_RESET      = 12'h000;
   localparam logic [31:0] CONFIG_RESET      = 32'h0000001e;
   localparam logic [31:0] CONFIG_RW_MASK    = 32'h00001fff;
   localparam int          CFG_ATTEN_BIT     = 0;
   localparam int          CFG_GAINSEL_BIT   = 12;
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;
   typedef enum logic [2:0] {
      FDC_W_IDLE = 3'h1,
      FDC_W_RESP = 3'h2,
      FDC_W_HOLD = 3'h4
   } fdc_wstate_t;
endpackage

// file: verification/fdc_cal_regs_properties.sv
// Purpose: bus and key checks
// Assumes: aw and w offered together
// Notes:   bound to fdc_cal_regs
`timescale 1ns/100ps
module fdc_cal_regs_properties
   import fdc_pkg::*;
(
   input wire logic        CLK_SYS,
   input wire logic        RESET,
   input wire logic [15:0] S_AXI_AWADDR,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0]  S_AXI_WSTRB,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic [11:0] GAIN_TRIM,
   input wire logic        CAL_UNLOCKED
);
   // ---
   // helpers
   // ---
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   logic key_a;
   logic map_a;
   assign key_a = S_AXI_AWADDR == OFS_UNLOCK_KEY && S_AXI_WSTRB == 4'hf;
   assign map_a = S_AXI_AWADDR inside {OFS_UNLOCK_KEY, OFS_GAIN_TRIM, OFS_ON_LOWPOWER,
      OFS_OFF_LOWPOWER, OFS_ON_FAST, OFS_OFF_FAST, OFS_DAC_CONFIG};
   sequence s_wr;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence s_key_wr;
      s_wr ##0 key_a;
   endsequence
   // ---
   // properties
   // ---
   a_write_resp: assert property (s_wr |=> ##1 S_AXI_BVALID)
      else $error("no write response");
   a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
   a_read_resp: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("no read response");
   a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata dropped");
   a_key_unlock: assert property (s_key_wr ##0 S_AXI_WDATA == KEY_UNLOCK |=>
      ##1 CAL_UNLOCKED) else $error("key did not unlock");
   a_key_relock: assert property (s_key_wr ##0 S_AXI_WDATA != KEY_UNLOCK |=>
      ##1 !CAL_UNLOCKED) else $error("key did not relock");
   a_locked_gain: assert property (s_wr ##0 !CAL_UNLOCKED &&
      S_AXI_AWADDR == OFS_GAIN_TRIM |=> ##2 $stable(GAIN_TRIM)) else $error("gain overwritten");
   a_unmapped_err: assert property (s_wr ##0 !map_a |=> ##1 S_AXI_BRESP == RESP_SLVERR)
      else $error("unmapped write not refused");
endmodule // fdc_cal_regs_properties

bind fdc_cal_regs fdc_cal_regs_properties u_props (.CLK_SYS, .RESET, .S_AXI_AWADDR,
   .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
   .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
   .S_AXI_RVALID, .S_AXI_RREADY, .GAIN_TRIM, .CAL_UNLOCKED);

// file: verification/fast_dac_calibration_regs_tb.sv
// Purpose: self-checking bench for fdc_cal_regs
// Assumes: 100 MHz clock, reset held 10 cycles
// Notes:   trims modelled in exp_trim
`timescale 1ns/100ps
module fast_dac_calibration_regs_tb;
   import fdc_pkg::*;
   logic        clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, hs = 0;
   logic [15:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdv, v;
   logic [3:0]  ws = 4'hf;
   logic [1:0]  br, rr;
   logic        bv, awr, wrr, arr, rv, at, gs, unl;
   logic [11:0] gt, ot, exp_trim [5];
   logic [11:0] cor [5] = '{12'h000, 12'h7ff, 12'h001, 12'hfff, 12'h800};
   logic [15:0] ofs [5] = '{OFS_GAIN_TRIM, OFS_ON_LOWPOWER, OFS_OFF_LOWPOWER, OFS_ON_FAST,
      OFS_OFF_FAST};
   int          fails = 0, n_tests = 0, seed = 68101, k;
   always #5 clk = ~clk;
   fdc_cal_regs u_dut (.CLK_SYS(clk), .RESET(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdv),
      .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .HIGH_SPEED_MODE(hs),
      .GAIN_TRIM(gt), .OFFSET_TRIM(ot), .ATTEN_ENABLE(at), .GAIN_SELECT(gs),
      .CAL_UNLOCKED(unl));
   // ---
   // tasks
   // ---
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      k = $random(seed) & 3;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b0;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrr) wv <= 1'b0;
         k = k - 1;
         if (k < 0) bry <= 1'b1;
      end while (!(bv && bry));
      chk("bresp", er, br);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
      k = $random(seed) & 3;
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b0;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         k = k - 1;
         if (k < 0) rry <= 1'b1;
      end while (!(rv && rry));
      chk("rdata", e, rdv);
      chk("rresp", er, rr);
   endtask
   task automatic finish_test;
      $display("tests %0d fails %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ---
   // scenarios
   // ---
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(OFS_UNLOCK_KEY, KEY_RESET, RESP_OKAY);
      chk("unlocked", 0, unl);
      for (int i = 0; i < 5; i++) begin
         exp_trim[i] = (i == 0) ? GAIN_RESET : OFFSET_RESET;
         rd(ofs[i], {20'h0, exp_trim[i]}, RESP_OKAY);
         wr(ofs[i], $random(seed), RESP_OKAY);
         rd(ofs[i], {20'h0, exp_trim[i]}, RESP_OKAY);
      end
      wr(OFS_UNLOCK_KEY, KEY_UNLOCK, RESP_OKAY);
      rd(OFS_UNLOCK_KEY, KEY_UNLOCK, RESP_OKAY);
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 5; i++) begin
            v = $random(seed);
            if (r == 0) v[11:0] = cor[i];
            exp_trim[i] = v[11:0];
            wr(ofs[i], v, RESP_OKAY);
            rd(ofs[i], {20'h0, v[11:0]}, RESP_OKAY);
         end
         for (int c = 0; c < 8; c++) begin
            wr(OFS_DAC_CONFIG, {19'h0, c[2], 11'h0, c[0]}, RESP_OKAY);
            hs <= c[1];
            repeat (2) @(posedge clk);
            chk("atten", c[0], at);
            chk("gainsel", c[2], gs);
            chk("gain_trim", exp_trim[0], gt);
            chk("offset_trim", exp_trim[1 + 2 * c[1] + !c[0]], ot);
         end
      end
      v = $random(seed) & 32'hfffffff0;
      wr(OFS_UNLOCK_KEY, v, RESP_OKAY);
      chk("unlocked", 0, unl);
      wr(OFS_GAIN_TRIM, ~exp_trim[0], RESP_OKAY);
      rd(OFS_GAIN_TRIM, {20'h0, exp_trim[0]}, RESP_OKAY);
      wr(16'h2270, v, RESP_SLVERR);
      rd(16'h2270, 32'h0, RESP_SLVERR);
      finish_test;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      finish_test;
   end
endmodule // fast_dac_calibration_regs_tb
